// >>> core/ts_rx_regs.svh
// Register offsets, field positions, reset values and stream constants
// for the transport stream receive control block.
// Assumes a 12-bit APB byte address and 32-bit data, one register a word.
// Notes on behaviour
// - DMA enable bit matters only while the stream interface is the source.
// - DMA enable 1 writes received data to memory; 0 writes none.
// - Writing run 1 from 0 starts accepting input bytes; 1 means active.
// - Writing run 0 from 1 stalls the receiver; 0 means inactive.
// - Stream interface issues no memory writes unless DMA enable is set.
// - DMA input port writes memory while running, ignoring DMA enable.
// - Bit 15 gates status interrupts to the processor: 0 blocks, 1 passes.
// - Bit 14 picks storage: 0 is 32-bit little, 1 is 64-bit big endian.
// - Filter on and bit 12 set: check table CRC, ignore failing packets.
// - Filter on and bit 9 set: ignore packets with transport error set.
// - Filter on and bit 8 set: ignore packets with a bad sync byte.
// - Filter on, bit 5 picks picture start: payload start or priority.
// - Port select 0 takes the stream interface, 1 the DMA interface.
// - Packet-ID filter acts only in transport stream format.
`ifndef TS_RX_REGS_SVH
`define TS_RX_REGS_SVH

`define RX_CTRL_OFS     12'h000
`define FLT_CTRL_OFS    12'h004
`define INT_STAT_OFS    12'h008
`define INT_MASK_OFS    12'h00C
`define RX_STAT_OFS     12'h010
`define TABLE_PID_OFS   12'h014

`define RUN_BIT         0
`define DMA_EN_BIT      1
`define PORT_SEL_BIT    4
`define FMT_BIT         5
`define IRQ_EN_BIT      15
`define ORDER_BIT       14
`define CRC_EN_BIT      12
`define TEI_EN_BIT      9
`define SYNC_EN_BIT     8
`define GOP_SEL_BIT     5
`define PIDF_EN_BIT     3

`define RX_CTRL_RST     32'h0000_0000
`define FLT_CTRL_RST    32'h0000_0000
`define RX_CTRL_MASK    32'h0000_003F
`define FLT_CTRL_MASK   32'h0000_D33F
`define TABLE_PID_RST   13'h1FFF
`define INT_RST         4'h0

`define INT_DROP_BIT    0
`define INT_TABLE_BIT   1
`define INT_GOP_BIT     2
`define INT_CRC_BIT     3

`define TS_PKT_LEN      9'd188
`define RAW_PKT_LEN     9'd256
`define SYNC_BYTE       8'h47
`define PAT_PID         13'h0000
`define CRC_INIT        32'hFFFF_FFFF
`define CRC_POLY        32'h04C1_1DB7

`endif

// >>> core/ts_rx_pkg.sv
// Types shared by the receive control block and its test bench.
// Assumes the constants of ts_rx_regs.svh.
package ts_rx_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   typedef struct packed {
      logic       valid;
      logic       start;
      logic [7:0] data;
   } byte_in_s;

   typedef struct packed {
      logic        valid;
      logic        wide;
      logic [63:0] data;
   } mem_wr_s;

   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_HEAD = 2'b01,
      PS_BODY = 2'b10,
      PS_DROP = 2'b11
   } pkt_state_e;

endpackage

// >>> core/ts_rx_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the group changes slowly against pclk.
`timescale 1ns/1ps
module ts_rx_sync #(
   parameter int W = 10
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;

   sync_s st_ff;
   sync_s nxt_st;

   always_comb begin
      nxt_st.meta   = din;
      nxt_st.stable = st_ff.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.stable;
endmodule

// >>> core/ts_rx_crc_step.sv
// One byte step of the MSB-first 32-bit table CRC.
// Purely combinational; the caller holds the running value.
`timescale 1ns/1ps
`include "ts_rx_regs.svh"
module ts_rx_crc_step (
   input  wire logic [31:0] crc_in,
   input  wire logic [7:0]  data,
   output logic      [31:0] crc_out
);
   logic [31:0] stage [0:8];

   assign stage[0] = crc_in;

   genvar b;
   generate
      for (b = 0; b < 8; b = b + 1) begin : g_bit
         assign stage[b+1] = (stage[b][31] ^ data[7-b])
                           ? ({stage[b][30:0], 1'b0} ^ `CRC_POLY)
                           : {stage[b][30:0], 1'b0};
      end
   endgenerate

   assign crc_out = stage[8];
endmodule

// >>> core/ts_rx_ctrl.sv
// Receive control block: APB registers, source select, packet filters,
// memory word packing and the processor interrupt.
// Assumes a memory writer that takes every mem_wr beat without stalling,
// and that table sections end exactly at the packet end (no padding).
`timescale 1ns/1ps
`include "ts_rx_regs.svh"
module ts_rx_ctrl (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire ts_rx_pkg::apb_req_s apb_req,
   output ts_rx_pkg::apb_rsp_s     apb_rsp,
   input  wire logic [7:0]         ts_data,
   input  wire logic               ts_valid,
   input  wire logic               ts_start,
   input  wire ts_rx_pkg::byte_in_s dma_in,
   output logic                    dma_ready,
   output ts_rx_pkg::mem_wr_s      mem_wr,
   output logic                    table_update,
   output logic                    picture_start,
   output logic                    irq
);
   import ts_rx_pkg::*;

   typedef struct packed {
      logic [31:0] rx_ctrl;
      logic [31:0] flt_ctrl;
      logic [12:0] table_pid;
      logic [3:0]  int_stat;
      logic [3:0]  int_mask;
      pkt_state_e  pst;
      logic [8:0]  idx;
      logic [7:0]  hdr1;
      logic [7:0]  hdr2;
      logic        sync_bad;
      logic        is_table;
      logic [31:0] crc;
      logic [63:0] acc;
      logic [3:0]  lanes;
      logic [15:0] drop_cnt;
      logic        dma_ready;
      apb_rsp_s    rsp;
      mem_wr_s     mem;
      logic        table_update;
      logic        picture_start;
      logic        irq;
   } ctrl_s;

   ctrl_s st_ff;
   ctrl_s nxt_st;

   logic [9:0]  ts_sync;
   byte_in_s    ts_in;
   byte_in_s    src;
   logic [31:0] crc_next;

   // Pins from the stream interface come from another clock domain
   ts_rx_sync #(
      .W (10)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({ts_valid, ts_start, ts_data}),
      .dout    (ts_sync)
   );

   assign ts_in.valid = ts_sync[9];
   assign ts_in.start = ts_sync[8];
   assign ts_in.data  = ts_sync[7:0];

   ts_rx_crc_step u_crc (
      .crc_in  (st_ff.crc),
      .data    (src.data),
      .crc_out (crc_next)
   );

   // Control bits decoded from the stored registers
   logic run;
   logic dma_en;
   logic port_sel;
   logic ts_fmt;
   logic order_big;
   logic filt_on;
   logic mem_en;
   logic [8:0] pkt_len;

   assign run       = st_ff.rx_ctrl[`RUN_BIT];
   assign dma_en    = st_ff.rx_ctrl[`DMA_EN_BIT];
   assign port_sel  = st_ff.rx_ctrl[`PORT_SEL_BIT];
   assign ts_fmt    = st_ff.rx_ctrl[`FMT_BIT];
   assign order_big = st_ff.flt_ctrl[`ORDER_BIT];
   // Filter options only exist in transport stream format
   assign filt_on   = ts_fmt & st_ff.flt_ctrl[`PIDF_EN_BIT];
   // DMA port writes regardless; stream port needs the enable
   assign mem_en    = port_sel | dma_en;
   assign pkt_len   = ts_fmt ? `TS_PKT_LEN : `RAW_PKT_LEN;

   always_comb begin
      // Source multiplexer
      src = port_sel ? dma_in : ts_in;
      // DMA port bytes count only while ready was shown
      src.valid = run &
                  (port_sel ? (dma_in.valid & st_ff.dma_ready) : ts_in.valid);
   end

   // Register read mux
   function automatic logic [32:0] reg_read(input logic [11:0] a,
                                            input ctrl_s s);
      logic [32:0] r;
      r = {1'b0, 32'h0000_0000};
      case (a)
         `RX_CTRL_OFS:   r[31:0] = s.rx_ctrl;
         `FLT_CTRL_OFS:  r[31:0] = s.flt_ctrl;
         `INT_STAT_OFS:  r[31:0] = {28'h000_0000, s.int_stat};
         `INT_MASK_OFS:  r[31:0] = {28'h000_0000, s.int_mask};
         `RX_STAT_OFS:   r[31:0] = {s.drop_cnt, 13'h0000,
                                    s.pst != PS_IDLE, mem_en, run};
         `TABLE_PID_OFS: r[31:0] = {19'h0_0000, s.table_pid};
         default:        r[32]   = 1'b1;
      endcase
      return r;
   endfunction

   logic        wr_fire;
   logic        first;
   logic [8:0]  idx_cur;
   logic        last;
   logic        drop_now;
   logic        table_now;
   logic        hold_mem;
   logic [2:0]  lane_pos;
   logic [63:0] acc_w;
   logic        word_full;
   logic [3:0]  ev;
   logic [32:0] rd;
   logic [12:0] pid;
   logic        crc_on;

   always_comb begin
      nxt_st    = st_ff;
      ev        = 4'h0;
      first     = 1'b0;
      idx_cur   = 9'h000;
      last      = 1'b0;
      drop_now  = 1'b0;
      table_now = 1'b0;
      hold_mem  = 1'b0;
      lane_pos  = 3'h0;
      acc_w     = st_ff.acc;
      word_full = 1'b0;
      pid       = {st_ff.hdr1[4:0], st_ff.hdr2};
      crc_on    = st_ff.flt_ctrl[`CRC_EN_BIT];
      rd        = reg_read(apb_req.paddr, st_ff);
      wr_fire   = apb_req.psel & apb_req.penable & apb_req.pwrite &
                  st_ff.rsp.pready;

      // APB slave: one wait-free access cycle after setup
      nxt_st.rsp.pready  = apb_req.psel & ~apb_req.penable;
      nxt_st.rsp.pslverr = apb_req.psel & ~apb_req.penable & rd[32];
      if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
         nxt_st.rsp.prdata = rd[31:0];
      end

      // Single-cycle outputs fall back every clock
      nxt_st.mem.valid     = 1'b0;
      nxt_st.table_update  = 1'b0;
      nxt_st.picture_start = 1'b0;
      nxt_st.mem.wide      = order_big;

      if (!run) begin
         // A stalled receiver forgets any half packet
         nxt_st.pst   = PS_IDLE;
         nxt_st.lanes = 4'h0;
         nxt_st.acc   = 64'h0000_0000_0000_0000;
      end else if (src.valid) begin
         first   = src.start | (st_ff.pst == PS_IDLE);
         idx_cur = first ? 9'h000 : st_ff.idx;
         last    = (idx_cur == pkt_len - 9'd1);

         if (first) begin
            nxt_st.sync_bad = (src.data != `SYNC_BYTE);
            nxt_st.is_table = 1'b0;
            nxt_st.crc      = `CRC_INIT;
            nxt_st.pst      = PS_HEAD;
            acc_w           = 64'h0000_0000_0000_0000;
         end
         if (idx_cur == 9'd1) begin
            nxt_st.hdr1 = src.data;
         end
         if (idx_cur == 9'd2) begin
            nxt_st.hdr2 = src.data;
         end

         // Header decisions land on byte 3, before any word leaves
         if (ts_fmt && idx_cur == 9'd3) begin
            drop_now = filt_on &
               ((st_ff.flt_ctrl[`SYNC_EN_BIT] & st_ff.sync_bad) |
                (st_ff.flt_ctrl[`TEI_EN_BIT] & st_ff.hdr1[7]));
            table_now = filt_on & ~drop_now &
                        (pid == `PAT_PID || pid == st_ff.table_pid);
            nxt_st.is_table = table_now;
            nxt_st.pst      = drop_now ? PS_DROP : PS_BODY;
            if (drop_now) begin
               ev[`INT_DROP_BIT] = 1'b1;
            end
            // Picture-group start condition
            if (filt_on & ~drop_now &
                (st_ff.flt_ctrl[`GOP_SEL_BIT] ? st_ff.hdr1[5]
                                              : st_ff.hdr1[6])) begin
               nxt_st.picture_start = 1'b1;
               ev[`INT_GOP_BIT]     = 1'b1;
            end
         end else if (!first && st_ff.pst == PS_HEAD && idx_cur > 9'd3) begin
            nxt_st.pst = PS_BODY;
         end

         // Table payload runs through the CRC
         if (st_ff.is_table && crc_on && idx_cur > 9'd3) begin
            nxt_st.crc = crc_next;
         end

         // Checked tables stay out of memory; dropped ones too
         hold_mem = ~mem_en | drop_now | (st_ff.pst == PS_DROP) |
                    ((table_now | st_ff.is_table) & crc_on);

         // Byte packing: low lane first or high lane first
         lane_pos = order_big ? (3'd7 - st_ff.lanes[2:0])
                              : st_ff.lanes[2:0];
         if (first) begin
            lane_pos = order_big ? 3'd7 : 3'd0;
         end
         acc_w[{lane_pos, 3'b000} +: 8] = src.data;
         word_full = first ? 1'b0
                   : (st_ff.lanes == (order_big ? 4'd7 : 4'd3));

         if (word_full || last) begin
            if (!hold_mem) begin
               nxt_st.mem.valid = 1'b1;
               nxt_st.mem.data  = acc_w;
            end
            nxt_st.acc   = 64'h0000_0000_0000_0000;
            nxt_st.lanes = 4'h0;
         end else begin
            nxt_st.acc   = acc_w;
            nxt_st.lanes = first ? 4'h1 : st_ff.lanes + 4'h1;
         end

         nxt_st.idx = idx_cur + 9'd1;
         if (last) begin
            nxt_st.pst = PS_IDLE;
            if (st_ff.is_table) begin
               if (!crc_on || crc_next == 32'h0000_0000) begin
                  nxt_st.table_update  = 1'b1;
                  ev[`INT_TABLE_BIT]   = 1'b1;
               end else begin
                  // Failing table counts as dropped
                  ev[`INT_CRC_BIT]  = 1'b1;
                  ev[`INT_DROP_BIT] = 1'b1;
               end
            end
         end
      end

      if (ev[`INT_DROP_BIT]) begin
         nxt_st.drop_cnt = st_ff.drop_cnt + 16'h0001;
      end

      // DMA port is offered bytes only while running on that port
      nxt_st.dma_ready = run & port_sel;

      // Register writes
      if (wr_fire) begin
         case (apb_req.paddr)
            `RX_CTRL_OFS: begin
               nxt_st.rx_ctrl = apb_req.pwdata & `RX_CTRL_MASK;
            end
            `FLT_CTRL_OFS: begin
               nxt_st.flt_ctrl = apb_req.pwdata & `FLT_CTRL_MASK;
            end
            `INT_MASK_OFS: begin
               nxt_st.int_mask = apb_req.pwdata[3:0];
            end
            `TABLE_PID_OFS: begin
               nxt_st.table_pid = apb_req.pwdata[12:0];
            end
            default: begin
            end
         endcase
      end

      // Write one to clear; a same-cycle event keeps its bit
      nxt_st.int_stat = st_ff.int_stat;
      if (wr_fire && apb_req.paddr == `INT_STAT_OFS) begin
         nxt_st.int_stat = st_ff.int_stat & ~apb_req.pwdata[3:0];
      end
      nxt_st.int_stat = nxt_st.int_stat | ev;

      // Processor interrupt gate
      nxt_st.irq = nxt_st.flt_ctrl[`IRQ_EN_BIT] &
                   (|(nxt_st.int_stat & nxt_st.int_mask));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff           <= '0;
         st_ff.rx_ctrl   <= `RX_CTRL_RST;
         st_ff.flt_ctrl  <= `FLT_CTRL_RST;
         st_ff.table_pid <= `TABLE_PID_RST;
         st_ff.int_stat  <= `INT_RST;
         st_ff.int_mask  <= `INT_RST;
         st_ff.pst       <= PS_IDLE;
         st_ff.crc       <= `CRC_INIT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign apb_rsp       = st_ff.rsp;
   assign dma_ready     = st_ff.dma_ready;
   assign mem_wr        = st_ff.mem;
   assign table_update  = st_ff.table_update;
   assign picture_start = st_ff.picture_start;
   assign irq           = st_ff.irq;
endmodule

// >>> test/ts_rx_ctrl_sva.sv
// Port-level assertions for the receive control block.
// Assumes one clock, async active-low reset; bound from the bench top.
`timescale 1ns/1ps
`include "ts_rx_regs.svh"
module ts_rx_ctrl_sva (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire ts_rx_pkg::apb_req_s apb_req,
   input wire ts_rx_pkg::apb_rsp_s apb_rsp,
   input wire logic [7:0]          ts_data,
   input wire logic                ts_valid,
   input wire logic                ts_start,
   input wire ts_rx_pkg::byte_in_s dma_in,
   input wire logic                dma_ready,
   input wire ts_rx_pkg::mem_wr_s  mem_wr,
   input wire logic                table_update,
   input wire logic                picture_start,
   input wire logic                irq
);
   import ts_rx_pkg::*;
   logic [31:0] rx_ff;
   logic [31:0] fl_ff;
   logic        wr_ok;
   // Shadow copies of the control words, seen only through the bus
   assign wr_ok = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & apb_rsp.pready & ~apb_rsp.pslverr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_ff <= '0;
         fl_ff <= '0;
      end else if (wr_ok && apb_req.paddr == `RX_CTRL_OFS) begin
         rx_ff <= apb_req.pwdata;
      end else if (wr_ok && apb_req.paddr == `FLT_CTRL_OFS) begin
         fl_ff <= apb_req.pwdata;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_access;
      apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence
   chk_ready_next:
      assert property (s_setup |=> s_access)
      else $error("pready not a single cycle after setup");
   chk_err_unmapped:
      assert property (apb_rsp.pready |->
                       apb_rsp.pslverr == !(apb_req.paddr inside
                          {`RX_CTRL_OFS, `FLT_CTRL_OFS, `INT_STAT_OFS,
                           `INT_MASK_OFS, `RX_STAT_OFS, `TABLE_PID_OFS}))
      else $error("pslverr does not match address");
   chk_dma_ready:
      assert property (dma_ready == $past(rx_ff[0] & rx_ff[4]))
      else $error("dma_ready not run and port select");
   chk_stream_gate:
      assert property (mem_wr.valid |-> rx_ff[1] | rx_ff[4])
      else $error("memory write from stream without dma enable");
   chk_run_gate:
      assert property (mem_wr.valid |-> rx_ff[0])
      else $error("memory write while stalled");
   chk_irq_enable:
      // irq is registered from the next control value, so the shadow
      // written on the same edge is the one to compare against
      assert property (irq |-> fl_ff[15])
      else $error("irq while interrupt enable clear");
   chk_wide_order:
      assert property (mem_wr.valid |-> mem_wr.wide == fl_ff[14])
      else $error("word format differs from order bit");
   chk_word_gap:
      assert property (mem_wr.valid |=> !mem_wr.valid [*3])
      else $error("memory words closer than four bytes");
   chk_pic_filter:
      assert property (picture_start |-> fl_ff[3] && rx_ff[5])
      else $error("picture start without filter in stream format");
endmodule

// >>> test/ts_src_model.sv
// Stream source: drives the pin interface or the DMA byte port.
// Assumes send is called right after a rising pclk edge.
`timescale 1ns/1ps
module ts_src_model (
   input  wire logic           pclk,
   input  wire logic           dma_ready,
   output logic [7:0]          ts_data,
   output logic                ts_valid,
   output logic                ts_start,
   output ts_rx_pkg::byte_in_s dma_in
);
   import ts_rx_pkg::*;
   initial begin
      ts_data = 8'h00;
      ts_valid = 1'b0;
      ts_start = 1'b0;
      dma_in = '0;
   end
   // Header byte 2 is 0, byte 3 is 10h, payload byte k carries k
   function automatic logic [7:0] pbyte(int k, logic [7:0] b0, b1);
      return (k == 0) ? b0 : (k == 1) ? b1 : (k == 2) ? 8'h00 :
             (k == 3) ? 8'h10 : k[7:0];
   endfunction
   task automatic send(input logic dma, input logic [7:0] b0, b1,
                       input int len);
      for (int k = 0; k < len; k++) begin
         if (dma) begin
            dma_in <= '{1'b1, (k == 0), pbyte(k, b0, b1)};
            do @(posedge pclk); while (dma_ready !== 1'b1);
         end else begin
            ts_valid <= 1'b1;
            ts_start <= (k == 0);
            ts_data <= pbyte(k, b0, b1);
            @(posedge pclk);
         end
      end
      // Released lines show the inverse, never a stale valid byte
      ts_valid <= 1'b0;
      ts_start <= 1'b0;
      ts_data <= ~ts_data;
      dma_in <= '{1'b0, 1'b0, ~dma_in.data};
   endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the receive control block.
// Assumes the source model and the checker compile before this file.
`timescale 1ns/1ps
`include "ts_rx_regs.svh"
module tb;
   import ts_rx_pkg::*;
   typedef struct {
      logic [31:0] rxc;
      logic [31:0] flc;
      logic [7:0]  b0;
      logic [7:0]  b1;
      bit          mem;
      bit          pic;
      bit          tab;
   } row_s;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   apb_req_s    apb_req = '0;
   apb_rsp_s    apb_rsp;
   logic [7:0]  ts_data;
   logic        ts_valid;
   logic        ts_start;
   byte_in_s    dma_in;
   logic        dma_ready;
   mem_wr_s     mem_wr;
   logic        table_update;
   logic        picture_start;
   logic        irq;
   int          n_fail = 0;
   int          total_checks = 0;
   int          nw;
   int          np;
   int          nt;
   int          len;
   logic        wide;
   logic [63:0] first;
   logic [63:0] want;
   logic [31:0] rd;
   logic        err;
   row_s        rows[15] = '{
      '{32'h23, 32'h0000, 8'h47, 8'h01, 1, 0, 0},
      '{32'h21, 32'h0000, 8'h47, 8'h01, 0, 0, 0},
      '{32'h31, 32'h0000, 8'h47, 8'h01, 1, 0, 0},
      '{32'h23, 32'h4000, 8'h47, 8'h01, 1, 0, 0},
      '{32'h23, 32'h0208, 8'h47, 8'h81, 0, 0, 0},
      '{32'h23, 32'h0200, 8'h47, 8'h81, 1, 0, 0},
      '{32'h23, 32'h0108, 8'h46, 8'h01, 0, 0, 0},
      '{32'h03, 32'h0108, 8'h46, 8'h01, 1, 0, 0},
      '{32'h23, 32'h0008, 8'h47, 8'h41, 1, 1, 0},
      '{32'h23, 32'h0028, 8'h47, 8'h21, 1, 1, 0},
      '{32'h23, 32'h0028, 8'h47, 8'h41, 1, 0, 0},
      '{32'h23, 32'h0008, 8'h47, 8'h00, 1, 0, 1},
      '{32'h23, 32'h1008, 8'h47, 8'h00, 0, 0, 0},
      '{32'h22, 32'h0000, 8'h47, 8'h01, 0, 0, 0},
      '{32'h33, 32'h4000, 8'h47, 8'h01, 1, 0, 0}
   };
   always #4 pclk = ~pclk;
   ts_rx_ctrl dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .ts_data(ts_data), .ts_valid(ts_valid),
      .ts_start(ts_start), .dma_in(dma_in), .dma_ready(dma_ready),
      .mem_wr(mem_wr), .table_update(table_update),
      .picture_start(picture_start), .irq(irq));
   ts_src_model src_u (.pclk(pclk), .dma_ready(dma_ready),
      .ts_data(ts_data), .ts_valid(ts_valid), .ts_start(ts_start),
      .dma_in(dma_in));
   always @(posedge pclk) begin
      if (mem_wr.valid === 1'b1) begin
         if (nw == 0)
            first = mem_wr.data;
         nw++;
      end
      np += (picture_start === 1'b1);
      nt += (table_update === 1'b1);
   end
   task automatic chk(input string nm, input logic [63:0] e, got);
      total_checks++;
      if (got !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge pclk);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
      chk("pslverr", ee, err);
   endtask
   task automatic results;
      if (n_fail == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      results;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("irq", 0, irq);
      rdc("rx_ctrl", `RX_CTRL_OFS, `RX_CTRL_RST, 0);
      rdc("flt_ctrl", `FLT_CTRL_OFS, `FLT_CTRL_RST, 0);
      rdc("table_pid", `TABLE_PID_OFS, `TABLE_PID_RST, 0);
      rdc("int_stat", `INT_STAT_OFS, 0, 0);
      rdc("int_mask", `INT_MASK_OFS, 0, 0);
      apb(1'b1, 12'h040, 32'hFFFF_FFFF);
      rdc("unmapped", 12'h040, 0, 1);
      apb(1'b1, `RX_CTRL_OFS, 32'hFFFF_FFFF);
      rdc("rx_bits", `RX_CTRL_OFS, `RX_CTRL_MASK, 0);
      apb(1'b1, `FLT_CTRL_OFS, 32'hFFFF_FFFF);
      rdc("flt_bits", `FLT_CTRL_OFS, `FLT_CTRL_MASK, 0);
      foreach (rows[i]) begin
         apb(1'b1, `FLT_CTRL_OFS, rows[i].flc);
         apb(1'b1, `RX_CTRL_OFS, rows[i].rxc);
         nw = 0;
         np = 0;
         nt = 0;
         len = rows[i].rxc[5] ? 188 : 256;
         wide = rows[i].flc[14];
         src_u.send(rows[i].rxc[4], rows[i].b0, rows[i].b1, len);
         repeat (16) @(posedge pclk);
         want = !rows[i].mem ? 0 : wide ? (len + 7) / 8 : (len + 3) / 4;
         chk("words", want, nw);
         chk("pictures", rows[i].pic, np);
         chk("tables", rows[i].tab, nt);
         want = {rows[i].b0, rows[i].b1, 16'h0010, 32'h0405_0607};
         if (!wide)
            want = {32'h0, 16'h1000, rows[i].b1, rows[i].b0};
         if (nw > 0)
            chk("word0", want, wide ? first : {32'h0, first[31:0]});
      end
      apb(1'b1, `RX_CTRL_OFS, 32'h0);
      chk("irq_masked", 0, irq);
      apb(1'b1, `INT_MASK_OFS, 32'h4);
      apb(1'b1, `FLT_CTRL_OFS, 32'h8008);
      @(posedge pclk);
      chk("irq_on", 1, irq);
      apb(1'b1, `FLT_CTRL_OFS, 32'h0008);
      @(posedge pclk);
      chk("irq_gated", 0, irq);
      apb(1'b1, `FLT_CTRL_OFS, 32'h8008);
      apb(1'b1, `INT_STAT_OFS, 32'h4);
      @(posedge pclk);
      chk("irq_clear", 0, irq);
      rdc("int_stat", `INT_STAT_OFS, 32'hB, 0);
      apb(1'b1, `INT_MASK_OFS, 32'hF);
      chk("irq_pend", 1, irq);
      // Mid-run reset must drop the pending interrupt and the registers
      presetn <= 1'b0;
      @(posedge pclk);
      chk("irq_rst", 0, irq);
      repeat (7) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("irq_rel", 0, irq);
      rdc("int_stat_rst", `INT_STAT_OFS, 0, 0);
      rdc("flt_rst", `FLT_CTRL_OFS, `FLT_CTRL_RST, 0);
      rdc("int_mask_rst", `INT_MASK_OFS, 0, 0);
      results;
   end
endmodule
bind ts_rx_ctrl ts_rx_ctrl_sva chk_u (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .ts_data(ts_data),
   .ts_valid(ts_valid), .ts_start(ts_start), .dma_in(dma_in),
   .dma_ready(dma_ready), .mem_wr(mem_wr), .table_update(table_update),
   .picture_start(picture_start), .irq(irq));
